//--- seg_desc_pkg.sv
// Constants for the segment descriptor decoder: register map, descriptor
// field positions, system type codes and fault vectors.
// Assumes descriptors arrive as two 32-bit words, low word first in memory.
package seg_desc_pkg;

  // ****************************************
  // Register byte offsets
  // ****************************************
  localparam logic [7:0] OFS_DESC_LO = 8'h00;
  localparam logic [7:0] OFS_DESC_HI = 8'h04;
  localparam logic [7:0] OFS_CTRL = 8'h08;
  localparam logic [7:0] OFS_OFFSET = 8'h0c;
  localparam logic [7:0] OFS_TARGET = 8'h10;
  localparam logic [7:0] OFS_ATTR = 8'h14;
  localparam logic [7:0] OFS_STATUS = 8'h18;
  localparam logic [7:0] OFS_BASE = 8'h1c;
  localparam logic [7:0] OFS_LIMIT = 8'h20;
  localparam logic [7:0] OFS_TASK = 8'h24;
  localparam logic [7:0] OFS_ENT_SEL = 8'h28;
  localparam logic [7:0] OFS_ENT_OFF = 8'h2c;

  // ****************************************
  // Control bits
  // ****************************************
  localparam int CTL_LOAD = 0;
  localparam int CTL_GDT = 1;
  localparam int CTL_PRIV = 2;
  localparam int CTL_WRITE = 3;
  localparam int CTL_STACK = 4;
  localparam int CTL_LTR = 5;
  localparam int CTL_W = 6;

  // ****************************************
  // Descriptor high word fields
  // ****************************************
  localparam int HI_ACC = 8;
  localparam int HI_WR = 9;
  localparam int HI_ED = 10;
  localparam int HI_EX = 11;
  localparam int HI_S = 12;
  localparam int HI_P = 15;
  localparam int HI_B = 22;
  localparam int HI_G = 23;
  localparam int PAGE_BITS = 12;

  // ****************************************
  // System type codes
  // ****************************************
  localparam logic [3:0] T_INV0 = 4'h0;
  localparam logic [3:0] T_TSS16A = 4'h1;
  localparam logic [3:0] T_LDT = 4'h2;
  localparam logic [3:0] T_TSS16B = 4'h3;
  localparam logic [3:0] T_CALL16 = 4'h4;
  localparam logic [3:0] T_TASKG = 4'h5;
  localparam logic [3:0] T_INT16 = 4'h6;
  localparam logic [3:0] T_TRAP16 = 4'h7;
  localparam logic [3:0] T_INV8 = 4'h8;
  localparam logic [3:0] T_TSS32A = 4'h9;
  localparam logic [3:0] T_RSVA = 4'ha;
  localparam logic [3:0] T_TSS32B = 4'hb;
  localparam logic [3:0] T_CALL32 = 4'hc;
  localparam logic [3:0] T_RSVD = 4'hd;
  localparam logic [3:0] T_INT32 = 4'he;
  localparam logic [3:0] T_TRAP32 = 4'hf;

  // ****************************************
  // Fault vectors and stack bounds
  // ****************************************
  localparam logic [7:0] VEC_GP = 8'h0d;
  localparam logic [7:0] VEC_NP = 8'h0b;
  localparam logic [31:0] UB_STK16 = 32'h0000ffff;
  localparam logic [31:0] UB_STK32 = 32'h0fffffff;

  // ****************************************
  // Attribute and status bit positions
  // ****************************************
  localparam int AT_CODE = 0;
  localparam int AT_DATA = 1;
  localparam int AT_SYS = 2;
  localparam int AT_LEG = 3;
  localparam int AT_OP32 = 4;
  localparam int AT_CONF = 5;
  localparam int AT_EDOWN = 6;
  localparam int AT_WR = 7;
  localparam int AT_RD = 8;
  localparam int AT_STK32 = 9;
  localparam int AT_GRAN = 10;
  localparam int AT_PRES = 11;
  localparam int AT_BUSY = 12;
  localparam int AT_CLS = 16;
  localparam int ST_FAULT = 0;
  localparam int ST_UNUSE = 1;
  localparam int ST_OFS_OK = 2;
  localparam int ST_CLRIF = 3;
  localparam int ST_CNT32 = 4;
  localparam int ST_VEC = 8;
  localparam int ST_CNT = 16;

  typedef enum logic [3:0] {
    CL_NONE = 4'h0,
    CL_CODE = 4'h1,
    CL_DATA = 4'h2,
    CL_LDT = 4'h3,
    CL_TSS = 4'h4,
    CL_CALL = 4'h5,
    CL_TASKG = 4'h6,
    CL_INT = 4'h7,
    CL_TRAP = 4'h8
  } cls_t;

endpackage

//--- seg_desc_decode.sv
// Segment and system descriptor decoder with an APB register front end.
// Assumes an APB master on the core clock; decoded results feed the core.
//
// What this block does
// - Code default-size flag 1 gives 32-bit operands and addressing, else 16-bit.
// - Conforming code segments may run and be shared across privilege levels.
// - Expand-down stack segments accept only offsets strictly above the limit.
// - Expand-up data segments accept only offsets at or below the limit.
// - Data with writable 0 is read-only; a stack segment needs writable 1.
// - Stack-size flag picks 32-bit or 16-bit stack pointer, with upper bound 32'h0fffffff or 32'h0000ffff.
// - System descriptors carry 32-bit base, 20-bit limit; zero upper half is legacy.
// - Legacy system descriptors use a 24-bit base and 16-bit limit.
// - Type 2 is a local table; privilege ignored; allowed only in global table.
// - Types 1,3 legacy task segments free/busy; 9,B 32-bit free/busy.
// - Types 4,6,7 legacy gates, 5 task gate, C,E,F 32-bit gates.
// - Types 0 and 8 invalid; A and D reserved and undefined.
// - The task register holds the current task state segment selector.
// - Call gate with privilege change copies word-count parameters; others ignore it.
// - Interrupt and trap gates give selector and offset as handler entry.
// - Interrupt gate entry clears interrupt enable; trap gate leaves it.
// - Task gate uses only its selector, which must name a task segment.
// - Wrong destination descriptor type raises exception 13.
// - Gate with present flag 0 is invalid and raises exception 11.
// - System or gate descriptors are recognised only with system flag 0.
// - The accessed flag is set whenever a descriptor is accessed.
// - Executable 1 with system 1 is code; executable 0 with system 1 is data.
// - Granularity 0 gives byte limit, 1 gives 4-Kbyte pages, regardless of paging.
//
// Design decisions made here: the placing of the registers and register access over APB.
`timescale 1ns/100ps
module seg_desc_decode #(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  // APB slave
  input wire logic [ADDR_W-1:0] paddr_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // Decoded results for the core
  output logic op32_out,
  output logic addr32_out,
  output logic stack32_out,
  output logic offset_ok_out,
  output logic fault_out,
  output logic [7:0] fault_vec_out,
  output logic clear_if_out
);

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic is_tss(input logic [3:0] t);
    is_tss = (t == seg_desc_pkg::T_TSS16A) || (t == seg_desc_pkg::T_TSS16B) ||
             (t == seg_desc_pkg::T_TSS32A) || (t == seg_desc_pkg::T_TSS32B);
  endfunction

  function automatic logic is_bad(input logic [3:0] t);
    is_bad = (t == seg_desc_pkg::T_INV0) || (t == seg_desc_pkg::T_INV8) ||
             (t == seg_desc_pkg::T_RSVA) || (t == seg_desc_pkg::T_RSVD);
  endfunction

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] o);
    hit = (a == ADDR_W'(o));
  endfunction

  // ****************************************
  // Software-visible state
  // ****************************************
  logic [31:0] desc_lo_ff;
  logic [31:0] desc_hi_ff;
  logic [seg_desc_pkg::CTL_W-1:0] ctrl_ff;
  logic [31:0] offset_ff;
  logic [7:0] target_ff;
  logic [15:0] task_sel_ff;
  logic load_ff;
  logic [31:0] prdata_ff;
  logic wr_acc;
  logic setup;
  logic mapped;

  assign setup = psel_in && !penable_in;
  assign wr_acc = psel_in && penable_in && pwrite_in;
  assign mapped = hit(paddr_in, seg_desc_pkg::OFS_DESC_LO) ||
                  hit(paddr_in, seg_desc_pkg::OFS_DESC_HI) ||
                  hit(paddr_in, seg_desc_pkg::OFS_CTRL) ||
                  hit(paddr_in, seg_desc_pkg::OFS_OFFSET) ||
                  hit(paddr_in, seg_desc_pkg::OFS_TARGET) ||
                  hit(paddr_in, seg_desc_pkg::OFS_ATTR) ||
                  hit(paddr_in, seg_desc_pkg::OFS_STATUS) ||
                  hit(paddr_in, seg_desc_pkg::OFS_BASE) ||
                  hit(paddr_in, seg_desc_pkg::OFS_LIMIT) ||
                  hit(paddr_in, seg_desc_pkg::OFS_TASK) ||
                  hit(paddr_in, seg_desc_pkg::OFS_ENT_SEL) ||
                  hit(paddr_in, seg_desc_pkg::OFS_ENT_OFF);

  // Zero wait states: read data is captured during the setup phase
  assign pready_out = 1'b1;
  assign pslverr_out = psel_in && penable_in && !mapped;
  assign prdata_out = prdata_ff;

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      desc_lo_ff <= 32'h0;
    end else if (wr_acc && hit(paddr_in, seg_desc_pkg::OFS_DESC_LO)) begin
      desc_lo_ff <= pwdata_in;
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      desc_hi_ff <= 32'h0;
    end else if (wr_acc && hit(paddr_in, seg_desc_pkg::OFS_DESC_HI)) begin
      desc_hi_ff <= pwdata_in;
    end else if (load_ff) begin
      desc_hi_ff[seg_desc_pkg::HI_ACC] <= 1'b1;
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ctrl_ff <= '0;
      offset_ff <= 32'h0;
      target_ff <= 8'h0;
    end else if (wr_acc) begin
      if (hit(paddr_in, seg_desc_pkg::OFS_CTRL)) begin
        ctrl_ff <= pwdata_in[seg_desc_pkg::CTL_W-1:0];
      end
      if (hit(paddr_in, seg_desc_pkg::OFS_OFFSET)) begin
        offset_ff <= pwdata_in;
      end
      if (hit(paddr_in, seg_desc_pkg::OFS_TARGET)) begin
        target_ff <= pwdata_in[7:0];
      end
    end
  end

  // A load is one cycle behind the control write so decode sees new flags
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      load_ff <= 1'b0;
    end else begin
      load_ff <= wr_acc && hit(paddr_in, seg_desc_pkg::OFS_CTRL) &&
                 pwdata_in[seg_desc_pkg::CTL_LOAD];
    end
  end

  // ****************************************
  // Combinational decode of the staged descriptor
  // ****************************************
  logic [3:0] typ;
  logic sys_flag;
  logic legacy;
  logic [19:0] raw_lim;
  logic [31:0] nxt_base;
  logic [31:0] nxt_limit;
  logic [31:0] nxt_attr;
  logic [31:0] nxt_ent_off;
  logic nxt_fault;
  logic [7:0] nxt_vec;
  logic nxt_unuse;
  logic nxt_clrif;
  logic [4:0] nxt_cnt;
  logic nxt_cnt32;
  logic tgt_code;
  logic tgt_tss;
  seg_desc_pkg::cls_t nxt_cls;

  assign typ = desc_hi_ff[seg_desc_pkg::HI_EX:seg_desc_pkg::HI_ACC];
  assign sys_flag = desc_hi_ff[seg_desc_pkg::HI_S];
  assign legacy = !sys_flag && (desc_hi_ff[31:16] == 16'h0);
  assign raw_lim = {desc_hi_ff[19:16], desc_lo_ff[15:0]};
  assign tgt_code = target_ff[seg_desc_pkg::HI_S-8] && target_ff[seg_desc_pkg::HI_EX-8];
  assign tgt_tss = !target_ff[seg_desc_pkg::HI_S-8] &&
                   is_tss(target_ff[seg_desc_pkg::HI_EX-8:0]);

  always_comb begin
    nxt_cls = seg_desc_pkg::CL_NONE;
    nxt_fault = 1'b0;
    nxt_vec = 8'h0;
    nxt_unuse = 1'b0;
    nxt_clrif = 1'b0;
    nxt_cnt = 5'h0;
    nxt_cnt32 = 1'b0;
    nxt_ent_off = 32'h0;
    if (legacy) begin
      nxt_base = {8'h0, desc_hi_ff[7:0], desc_lo_ff[31:16]};
      nxt_limit = {16'h0, desc_lo_ff[15:0]};
    end else begin
      nxt_base = {desc_hi_ff[31:24], desc_hi_ff[7:0], desc_lo_ff[31:16]};
      if (desc_hi_ff[seg_desc_pkg::HI_G]) begin
        nxt_limit = {raw_lim, {seg_desc_pkg::PAGE_BITS{1'b1}}};
      end else begin
        nxt_limit = {12'h0, raw_lim};
      end
    end
    if (sys_flag) begin
      nxt_cls = typ[3] ? seg_desc_pkg::CL_CODE : seg_desc_pkg::CL_DATA;
      if (!desc_hi_ff[seg_desc_pkg::HI_P]) begin
        nxt_fault = 1'b1;
        nxt_vec = seg_desc_pkg::VEC_NP;
      end
    end else begin
      case (typ)
        seg_desc_pkg::T_LDT: begin
          nxt_cls = seg_desc_pkg::CL_LDT;
          if (!ctrl_ff[seg_desc_pkg::CTL_GDT]) begin
            nxt_fault = 1'b1;
            nxt_vec = seg_desc_pkg::VEC_GP;
          end
        end
        seg_desc_pkg::T_TSS16A, seg_desc_pkg::T_TSS16B,
        seg_desc_pkg::T_TSS32A, seg_desc_pkg::T_TSS32B: begin
          nxt_cls = seg_desc_pkg::CL_TSS;
        end
        seg_desc_pkg::T_CALL16, seg_desc_pkg::T_CALL32: begin
          nxt_cls = seg_desc_pkg::CL_CALL;
          if (ctrl_ff[seg_desc_pkg::CTL_PRIV]) begin
            nxt_cnt = desc_hi_ff[4:0];
            nxt_cnt32 = typ[3];
          end
        end
        seg_desc_pkg::T_TASKG: begin
          nxt_cls = seg_desc_pkg::CL_TASKG;
        end
        seg_desc_pkg::T_INT16, seg_desc_pkg::T_INT32: begin
          nxt_cls = seg_desc_pkg::CL_INT;
          nxt_clrif = 1'b1;
        end
        seg_desc_pkg::T_TRAP16, seg_desc_pkg::T_TRAP32: begin
          nxt_cls = seg_desc_pkg::CL_TRAP;
        end
        default: begin
          nxt_unuse = is_bad(typ);
          nxt_fault = 1'b1;
          nxt_vec = seg_desc_pkg::VEC_GP;
        end
      endcase
      if (nxt_cls == seg_desc_pkg::CL_CALL || nxt_cls == seg_desc_pkg::CL_INT ||
          nxt_cls == seg_desc_pkg::CL_TRAP) begin
        nxt_ent_off = typ[3] ? {desc_hi_ff[31:16], desc_lo_ff[15:0]}
                             : {16'h0, desc_lo_ff[15:0]};
        if (!tgt_code) begin
          nxt_fault = 1'b1;
          nxt_vec = seg_desc_pkg::VEC_GP;
        end
      end
      if (nxt_cls == seg_desc_pkg::CL_TASKG && !tgt_tss) begin
        nxt_fault = 1'b1;
        nxt_vec = seg_desc_pkg::VEC_GP;
      end
      // Absent gate outranks a bad destination
      if (nxt_cls >= seg_desc_pkg::CL_CALL && !desc_hi_ff[seg_desc_pkg::HI_P]) begin
        nxt_fault = 1'b1;
        nxt_vec = seg_desc_pkg::VEC_NP;
      end
    end
    nxt_attr = 32'h0;
    nxt_attr[seg_desc_pkg::AT_CODE] = sys_flag && typ[3];
    nxt_attr[seg_desc_pkg::AT_DATA] = sys_flag && !typ[3];
    nxt_attr[seg_desc_pkg::AT_SYS] = !sys_flag;
    nxt_attr[seg_desc_pkg::AT_LEG] = legacy;
    nxt_attr[seg_desc_pkg::AT_OP32] = desc_hi_ff[seg_desc_pkg::HI_B];
    nxt_attr[seg_desc_pkg::AT_CONF] = sys_flag && typ[3] && typ[2];
    nxt_attr[seg_desc_pkg::AT_EDOWN] = sys_flag && !typ[3] && typ[2];
    nxt_attr[seg_desc_pkg::AT_WR] = sys_flag && !typ[3] && typ[1];
    nxt_attr[seg_desc_pkg::AT_RD] = sys_flag && (!typ[3] || typ[1]);
    nxt_attr[seg_desc_pkg::AT_STK32] = desc_hi_ff[seg_desc_pkg::HI_B];
    nxt_attr[seg_desc_pkg::AT_GRAN] = desc_hi_ff[seg_desc_pkg::HI_G];
    nxt_attr[seg_desc_pkg::AT_PRES] = desc_hi_ff[seg_desc_pkg::HI_P];
    nxt_attr[seg_desc_pkg::AT_BUSY] = (nxt_cls == seg_desc_pkg::CL_TSS) && typ[1];
    nxt_attr[seg_desc_pkg::AT_CLS +: 4] = nxt_cls;
  end

  // ****************************************
  // Decoded state, held until the next load
  // ****************************************
  logic [31:0] attr_ff;
  logic [31:0] base_ff;
  logic [31:0] limit_ff;
  logic [31:0] ent_off_ff;
  logic [15:0] ent_sel_ff;
  logic fault_ff;
  logic [7:0] vec_ff;
  logic unuse_ff;
  logic clrif_ff;
  logic [4:0] cnt_ff;
  logic cnt32_ff;

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      attr_ff <= 32'h0;
      base_ff <= 32'h0;
      limit_ff <= 32'h0;
      ent_off_ff <= 32'h0;
      ent_sel_ff <= 16'h0;
      fault_ff <= 1'b0;
      vec_ff <= 8'h0;
      unuse_ff <= 1'b0;
      clrif_ff <= 1'b0;
      cnt_ff <= 5'h0;
      cnt32_ff <= 1'b0;
    end else if (load_ff) begin
      attr_ff <= nxt_attr;
      base_ff <= nxt_base;
      limit_ff <= nxt_limit;
      ent_off_ff <= nxt_ent_off;
      ent_sel_ff <= sys_flag ? 16'h0 : desc_lo_ff[31:16];
      fault_ff <= nxt_fault;
      vec_ff <= nxt_vec;
      unuse_ff <= nxt_unuse;
      clrif_ff <= nxt_clrif;
      cnt_ff <= nxt_cnt;
      cnt32_ff <= nxt_cnt32;
    end
  end

  // Task register: software write, or loaded with a selector on a task load
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      task_sel_ff <= 16'h0;
    end else if (wr_acc && hit(paddr_in, seg_desc_pkg::OFS_TASK)) begin
      task_sel_ff <= pwdata_in[15:0];
    end else if (load_ff && ctrl_ff[seg_desc_pkg::CTL_LTR] && !sys_flag &&
                 is_tss(typ) && !nxt_fault) begin
      task_sel_ff <= offset_ff[15:0];
    end
  end

  // ****************************************
  // Offset and access checks on held attributes
  // ****************************************
  logic ofs_ok;
  logic acc_ok;
  logic [31:0] stk_ub;

  assign stk_ub = attr_ff[seg_desc_pkg::AT_STK32] ? seg_desc_pkg::UB_STK32
                                                  : seg_desc_pkg::UB_STK16;
  always_comb begin
    if (attr_ff[seg_desc_pkg::AT_EDOWN]) begin
      ofs_ok = (offset_ff > limit_ff) && (offset_ff <= stk_ub);
    end else begin
      ofs_ok = offset_ff <= limit_ff;
    end
    if (ctrl_ff[seg_desc_pkg::CTL_STACK]) begin
      acc_ok = attr_ff[seg_desc_pkg::AT_WR];
    end else if (ctrl_ff[seg_desc_pkg::CTL_WRITE]) begin
      acc_ok = attr_ff[seg_desc_pkg::AT_WR];
    end else begin
      acc_ok = attr_ff[seg_desc_pkg::AT_RD];
    end
  end

  // ****************************************
  // Outputs to the core
  // ****************************************
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      op32_out <= 1'b0;
      addr32_out <= 1'b0;
      stack32_out <= 1'b0;
      offset_ok_out <= 1'b0;
      fault_out <= 1'b0;
      fault_vec_out <= 8'h0;
      clear_if_out <= 1'b0;
    end else begin
      op32_out <= attr_ff[seg_desc_pkg::AT_CODE] && attr_ff[seg_desc_pkg::AT_OP32];
      addr32_out <= attr_ff[seg_desc_pkg::AT_CODE] && attr_ff[seg_desc_pkg::AT_OP32];
      stack32_out <= attr_ff[seg_desc_pkg::AT_STK32];
      offset_ok_out <= ofs_ok && acc_ok && !fault_ff;
      fault_out <= fault_ff;
      fault_vec_out <= vec_ff;
      clear_if_out <= clrif_ff;
    end
  end

  // ****************************************
  // Read data, captured in the setup phase
  // ****************************************
  logic [31:0] status;

  always_comb begin
    status = 32'h0;
    status[seg_desc_pkg::ST_FAULT] = fault_ff;
    status[seg_desc_pkg::ST_UNUSE] = unuse_ff;
    status[seg_desc_pkg::ST_OFS_OK] = ofs_ok && acc_ok && !fault_ff;
    status[seg_desc_pkg::ST_CLRIF] = clrif_ff;
    status[seg_desc_pkg::ST_CNT32] = cnt32_ff;
    status[seg_desc_pkg::ST_VEC +: 8] = vec_ff;
    status[seg_desc_pkg::ST_CNT +: 5] = cnt_ff;
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      prdata_ff <= 32'h0;
    end else if (setup && !pwrite_in) begin
      case (paddr_in)
        ADDR_W'(seg_desc_pkg::OFS_DESC_LO): prdata_ff <= desc_lo_ff;
        ADDR_W'(seg_desc_pkg::OFS_DESC_HI): prdata_ff <= desc_hi_ff;
        ADDR_W'(seg_desc_pkg::OFS_CTRL): prdata_ff <= 32'(ctrl_ff);
        ADDR_W'(seg_desc_pkg::OFS_OFFSET): prdata_ff <= offset_ff;
        ADDR_W'(seg_desc_pkg::OFS_TARGET): prdata_ff <= {24'h0, target_ff};
        ADDR_W'(seg_desc_pkg::OFS_ATTR): prdata_ff <= attr_ff;
        ADDR_W'(seg_desc_pkg::OFS_STATUS): prdata_ff <= status;
        ADDR_W'(seg_desc_pkg::OFS_BASE): prdata_ff <= base_ff;
        ADDR_W'(seg_desc_pkg::OFS_LIMIT): prdata_ff <= limit_ff;
        ADDR_W'(seg_desc_pkg::OFS_TASK): prdata_ff <= {16'h0, task_sel_ff};
        ADDR_W'(seg_desc_pkg::OFS_ENT_SEL): prdata_ff <= {16'h0, ent_sel_ff};
        ADDR_W'(seg_desc_pkg::OFS_ENT_OFF): prdata_ff <= ent_off_ff;
        default: prdata_ff <= 32'h0;
      endcase
    end
  end

endmodule

//--- apb_master_model.sv
// APB master standing in for the core's register traffic.
// Assumes the slave samples on rising clk_in; one transfer at a time.
`timescale 1ns/100ps
module apb_master_model (
  // Clock
  input wire logic clk_in,
  // APB master side
  output logic [7:0] paddr_out = 8'h00,
  output logic psel_out = 1'b0,
  output logic penable_out = 1'b0,
  output logic pwrite_out = 1'b0,
  output logic [31:0] pwdata_out = 32'h00000000,
  input wire logic [31:0] prdata_in,
  input wire logic pready_in,
  input wire logic pslverr_in
);
  logic err_ff = 1'b0;

  // The released address and the unused write data of a read get inverted values so stale data never looks valid
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge clk_in);
    psel_out <= 1'b1;
    pwrite_out <= wr;
    paddr_out <= a;
    pwdata_out <= wr ? d : ~pwdata_out;
    @(posedge clk_in);
    penable_out <= 1'b1;
    do @(posedge clk_in); while (pready_in !== 1'b1);
    q = prdata_in;
    err_ff = pslverr_in;
    psel_out <= 1'b0;
    penable_out <= 1'b0;
    paddr_out <= ~a;
  endtask
endmodule

//--- seg_desc_monitor.sv
// Checker on the decoder's ports, bound into seg_desc_decode.
// Assumes one clock domain with an active-low asynchronous reset.
`timescale 1ns/100ps
module seg_desc_monitor #(
  parameter int ADDR_W = 8
) (
  // Clock, reset and APB
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic [ADDR_W-1:0] paddr_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic pready_out,
  input wire logic pslverr_out,
  // Core results
  input wire logic op32_out,
  input wire logic addr32_out,
  input wire logic stack32_out,
  input wire logic offset_ok_out,
  input wire logic fault_out,
  input wire logic [7:0] fault_vec_out,
  input wire logic clear_if_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!resetn_in);

  size_pair_a: assert property (op32_out == addr32_out)
    else $error("operand and address size disagree");
  vec_known_a: assert property (fault_out |-> fault_vec_out inside {8'h0d, 8'h0b})
    else $error("fault with unknown vector");
  vec_idle_a: assert property (!fault_out |-> fault_vec_out == 8'h00)
    else $error("vector without fault");
  fault_block_a: assert property (fault_out |-> !offset_ok_out)
    else $error("offset accepted on faulted descriptor");
  ready_a: assert property (pready_out)
    else $error("wait state inserted");
  err_phase_a: assert property (pslverr_out |-> psel_in && penable_in)
    else $error("error outside access phase");
  err_mapped_a: assert property (psel_in && penable_in && paddr_in <= 8'h2c
    && paddr_in[1:0] == 2'b00 |-> !pslverr_out)
    else $error("error on mapped register");
  // Outputs other than offset_ok_out move only three edges after a write, never on their own
  result_hold_a: assert property ($changed({op32_out, stack32_out, fault_out,
    fault_vec_out, clear_if_out}) |-> $past(psel_in && penable_in && pwrite_in, 3))
    else $error("result changed without a load");
endmodule

bind seg_desc_decode seg_desc_monitor #(.ADDR_W(ADDR_W)) seg_desc_monitor_i (.*);

//--- testbench.sv
// Self-checking bench for seg_desc_decode, driven through apb_master_model.
// Assumes outputs settle three edges after the load write.
`timescale 1ns/100ps
module testbench;
  logic clk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic [7:0] paddr;
  logic psel, penable, pwrite, pready, pslverr;
  logic [31:0] pwdata, prdata, attr, stat, q;
  logic op32, addr32, stack32, ofs_ok, fault, clr_if;
  logic [7:0] vec;
  int mismatches = 0;
  int total_checks = 0;
  // Class per system type, nibble t for type t
  localparam logic [63:0] CLS_TAB = 64'h8705404087654340;

  always #2.5 clk_in = ~clk_in;

  apb_master_model apb_master_model_i (.clk_in(clk_in), .paddr_out(paddr), .psel_out(psel),
    .penable_out(penable), .pwrite_out(pwrite), .pwdata_out(pwdata), .prdata_in(prdata),
    .pready_in(pready), .pslverr_in(pslverr));
  seg_desc_decode seg_desc_decode_i (.clk_in(clk_in), .resetn_in(resetn_in), .paddr_in(paddr),
    .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .pwdata_in(pwdata),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr), .op32_out(op32),
    .addr32_out(addr32), .stack32_out(stack32), .offset_ok_out(ofs_ok), .fault_out(fault),
    .fault_vec_out(vec), .clear_if_out(clr_if));

  // ****************************************
  // Helpers
  // ****************************************
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] dummy;
    apb_master_model_i.xfer(1'b1, a, d, dummy);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    apb_master_model_i.xfer(1'b0, a, 32'h0, d);
  endtask

  // Load waits four edges since results land three edges after the write
  task automatic load(input logic [31:0] lo, hi, ofs, tgt, ctl);
    wr(seg_desc_pkg::OFS_DESC_LO, lo);
    wr(seg_desc_pkg::OFS_DESC_HI, hi);
    wr(seg_desc_pkg::OFS_OFFSET, ofs);
    wr(seg_desc_pkg::OFS_TARGET, tgt);
    wr(seg_desc_pkg::OFS_CTRL, ctl);
    repeat (4) @(posedge clk_in);
    rd(seg_desc_pkg::OFS_ATTR, attr);
    rd(seg_desc_pkg::OFS_STATUS, stat);
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic code_seg();
    load(32'h0, 32'h00409c00, 32'h0, 32'h0, 32'h1);
    check(32'(op32), 32'h1);
    check(32'(attr[5]), 32'h1);
    check(32'(attr[19:16]), 32'h1);
    rd(seg_desc_pkg::OFS_DESC_HI, q);
    check(q, 32'h00409d00);
    load(32'h0, 32'h00009c00, 32'h0, 32'h0, 32'h1);
    check(32'(addr32), 32'h0);
  endtask

  task automatic data_seg();
    load(32'h10, 32'h00009200, 32'h10, 32'h0, 32'h9);
    check(32'(ofs_ok), 32'h1);
    check(32'(attr[19:16]), 32'h2);
    load(32'h10, 32'h00009200, 32'h11, 32'h0, 32'h9);
    check(32'(ofs_ok), 32'h0);
    load(32'h10, 32'h00009000, 32'h10, 32'h0, 32'h9);
    check(32'(ofs_ok), 32'h0);
  endtask

  task automatic stack_seg();
    load(32'h10, 32'h00409600, 32'h10, 32'h0, 32'h11);
    check(32'(ofs_ok), 32'h0);
    check(32'(stack32), 32'h1);
    load(32'h10, 32'h00409600, 32'h11, 32'h0, 32'h11);
    check(32'(ofs_ok), 32'h1);
    load(32'h10, 32'h00009600, 32'h10000, 32'h0, 32'h11);
    check(32'(ofs_ok), 32'h0);
    check(32'(stack32), 32'h0);
  endtask

  task automatic sys_types();
    for (int t = 0; t < 16; t++) begin
      load(32'h0, 32'h00018000 | (32'(t) << 8), 32'h0, (t == 5) ? 32'h89 : 32'h9a, 32'h3);
      check(32'(attr[19:16]), 32'(CLS_TAB[4*t +: 4]));
      check(32'(stat[1]), 32'(t == 0 || t == 8 || t == 10 || t == 13));
      check(32'(clr_if), 32'(t == 6 || t == 14));
    end
  endtask

  task automatic gate_faults();
    load(32'h0, 32'h00010c00, 32'h0, 32'h9a, 32'h3);
    check(32'(vec), 32'h0b);
    load(32'h0, 32'h00018c00, 32'h0, 32'h92, 32'h3);
    check(32'(vec), 32'h0d);
    load(32'h0, 32'h00018500, 32'h0, 32'h9a, 32'h3);
    check(32'(fault), 32'h1);
    load(32'h0, 32'h00018200, 32'h0, 32'h0, 32'h1);
    check(32'(vec), 32'h0d);
  endtask

  task automatic task_segs();
    load(32'h12345678, 32'h00008956, 32'h28, 32'h0, 32'h23);
    check(32'(attr[3]), 32'h1);
    rd(seg_desc_pkg::OFS_BASE, q);
    check(q, 32'h00561234);
    rd(seg_desc_pkg::OFS_LIMIT, q);
    check(q, 32'h00005678);
    rd(seg_desc_pkg::OFS_TASK, q);
    check(q, 32'h00000028);
    load(32'h12345678, 32'hab0f8956, 32'h0, 32'h0, 32'h3);
    rd(seg_desc_pkg::OFS_BASE, q);
    check(q, 32'hab561234);
    rd(8'h80, q);
    check(q, 32'h0);
    check(32'(apb_master_model_i.err_ff), 32'h1);
  endtask

  task automatic gate_entry();
    load(32'h00281234, 32'habcd8c03, 32'h0, 32'h9a, 32'h7);
    check(32'(stat[20:16]), 32'h3);
    rd(seg_desc_pkg::OFS_ENT_OFF, q);
    check(q, 32'habcd1234);
    rd(seg_desc_pkg::OFS_ENT_SEL, q);
    check(q, 32'h00000028);
    load(32'h00281234, 32'habcd8f03, 32'h0, 32'h9a, 32'h7);
    check(32'(stat[20:16]), 32'h0);
    load(32'h10, 32'h00809200, 32'h10fff, 32'h0, 32'h9);
    check(32'(ofs_ok), 32'h1);
    rd(seg_desc_pkg::OFS_LIMIT, q);
    check(q, 32'h00010fff);
  endtask

  initial begin
    #50000;
    mismatches++;
    results();
  end

  initial begin
    repeat (4) @(posedge clk_in);
    resetn_in <= 1'b1;
    code_seg();
    data_seg();
    stack_seg();
    sys_types();
    gate_faults();
    task_segs();
    gate_entry();
    results();
  end
endmodule
